// ---- ssl_supervisor.sv ----
// Supply supervisor: reset stretch, watchdog, supply flags, chip-select gating
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module ssl_supervisor
   import ssl_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic SUPPLY_BELOW_THR_IN,
   input wire logic SUPPLY_BELOW_BATT_IN,
   input wire logic POWERFAIL_SENSE_IN,
   input wire logic WATCHDOG_STROBE_IN,
   input wire logic WATCHDOG_STROBE_FLOAT_IN,
   input wire logic CHIP_SELECT_N_IN,
   input wire logic TIMEBASE_SELECT_IN,
   input wire logic TIMEBASE_PIN_IN,
   output logic RESET_N_OUT,
   output logic RESET_OUT,
   output logic SUPPLY_LOW_N_OUT,
   output logic WATCHDOG_EXPIRED_N_OUT,
   output logic POWERFAIL_WARN_N_OUT,
   output logic ON_BATTERY_FLAG_OUT,
   output logic CHIP_SELECT_N_OUT
);
   // ----------------------------------------------------------------
   // Period decode, shared by reset stretch and watchdog
   // ----------------------------------------------------------------
   function automatic logic [CNT_W-1:0] period_limit(input logic internal,
                                                     input logic pin_hi,
                                                     input logic [1:0] kind);
      logic [CNT_W-1:0] lim;
      lim = INT_LONG_TICKS;
      if (!internal) begin
         case (kind)
            KIND_RESET: lim = EXT_RESET_CLKS;
            KIND_SHORT: lim = EXT_SHORT_CLKS;
            default: lim = EXT_LONG_CLKS;
         endcase
      end else begin
         case (kind)
            KIND_RESET: lim = INT_RESET_TICKS;
            KIND_SHORT: lim = pin_hi ? INT_LONG_TICKS : INT_SHORT_TICKS;
            default: lim = INT_LONG_TICKS;
         endcase
      end
      return lim;
   endfunction : period_limit

   ssl_cmp_t cmp_raw;
   ssl_cmp_t cmp;
   ssl_state_t state_reg, state_next;
   ssl_out_t out_reg, out_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [23:0] pre_reg, pre_next;
   logic long_reg, long_next;
   logic strobe_last_reg, strobe_last_next;
   logic pin_last_reg, pin_last_next;
   logic sup_inv, backup, tick, edge_seen, cnt_done;
   logic [CNT_W-1:0] lim;

   // ----------------------------------------------------------------
   // Comparator synchronisation
   // ----------------------------------------------------------------
   assign cmp_raw = '{below_batt: SUPPLY_BELOW_BATT_IN, below_thr: SUPPLY_BELOW_THR_IN,
                      pf_ok: POWERFAIL_SENSE_IN};
   ssl_sync u_sync (
      .clk_in(REF_CLK_IN),
      .rst_in(RST_IN),
      .d_in(cmp_raw),
      .q_out(cmp)
   );

   // ----------------------------------------------------------------
   // Timebase, strobe edges and next state
   // ----------------------------------------------------------------
   always_comb begin
      backup = cmp.below_batt;
      sup_inv = cmp.below_thr | cmp.below_batt;
      pre_next = (pre_reg == 24'(TICK_CYCLES - 1)) ? 24'h000000 : pre_reg + 24'h000001;
      pin_last_next = TIMEBASE_PIN_IN;
      // External timebase counts rising edges of the pin as ticks
      tick = TIMEBASE_SELECT_IN ? (pre_reg == 24'(TICK_CYCLES - 1))
                                : (TIMEBASE_PIN_IN && !pin_last_reg);
      // Last level is frozen while floating so a float gap is no edge
      edge_seen = !sup_inv && !WATCHDOG_STROBE_FLOAT_IN &&
                  (WATCHDOG_STROBE_IN != strobe_last_reg);
      strobe_last_next = (sup_inv || WATCHDOG_STROBE_FLOAT_IN) ? strobe_last_reg
                                                                : WATCHDOG_STROBE_IN;
      lim = period_limit(TIMEBASE_SELECT_IN, TIMEBASE_PIN_IN,
                         (state_reg == ST_STRETCH) ? KIND_RESET :
                         (long_reg ? KIND_LONG : KIND_SHORT));
      cnt_done = tick && (cnt_reg == lim - 13'h0001);
      state_next = state_reg;
      cnt_next = cnt_reg;
      long_next = long_reg;
      out_next = out_reg;
      case (state_reg)
         ST_OFF: begin
            cnt_next = 13'h0000;
            if (!sup_inv) begin
               state_next = ST_STRETCH;
            end
         end
         ST_STRETCH: begin
            if (tick) begin
               cnt_next = cnt_reg + 13'h0001;
            end
            if (cnt_done) begin
               state_next = ST_RUN;
               cnt_next = 13'h0000;
               long_next = 1'b1;
            end
         end
         ST_RUN: begin
            if (WATCHDOG_STROBE_FLOAT_IN) begin
               cnt_next = 13'h0000;
            end else if (edge_seen) begin
               cnt_next = 13'h0000;
               long_next = 1'b0;
            end else if (cnt_done) begin
               state_next = ST_STRETCH;
               cnt_next = 13'h0000;
            end else if (tick) begin
               cnt_next = cnt_reg + 13'h0001;
            end
         end
         default: begin
            state_next = ST_OFF;
            cnt_next = 13'h0000;
         end
      endcase
      if (sup_inv) begin
         state_next = ST_OFF;
      end
      // Expired flag: clear on edge, set on timeout; an edge or an invalid supply in the timeout cycle wins over the set
      if (edge_seen) begin
         out_next.wdo_n = 1'b1;
      end
      if (state_reg == ST_RUN && !WATCHDOG_STROBE_FLOAT_IN && !edge_seen && cnt_done) begin
         out_next.wdo_n = 1'b0;
      end
      if (sup_inv) begin
         out_next.wdo_n = 1'b1;
      end
      out_next.reset_n = (state_next == ST_RUN);
      out_next.reset = !(state_next == ST_RUN);
      out_next.low_n = !sup_inv;
      out_next.on_batt = backup;
      out_next.pfo_n = backup ? 1'b0 : cmp.pf_ok;
      out_next.cs_n = sup_inv ? 1'b1 : CHIP_SELECT_N_IN;
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_reg <= ST_OFF;
         out_reg <= OUT_RST;
         cnt_reg <= 13'h0000;
         pre_reg <= 24'h000000;
         long_reg <= 1'b1;
         strobe_last_reg <= 1'b0;
         pin_last_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         out_reg <= out_next;
         cnt_reg <= cnt_next;
         pre_reg <= pre_next;
         long_reg <= long_next;
         strobe_last_reg <= strobe_last_next;
         pin_last_reg <= pin_last_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from a flop
   // ----------------------------------------------------------------
   assign RESET_N_OUT = out_reg.reset_n;
   assign RESET_OUT = out_reg.reset;
   assign SUPPLY_LOW_N_OUT = out_reg.low_n;
   assign WATCHDOG_EXPIRED_N_OUT = out_reg.wdo_n;
   assign POWERFAIL_WARN_N_OUT = out_reg.pfo_n;
   assign ON_BATTERY_FLAG_OUT = out_reg.on_batt;
   assign CHIP_SELECT_N_OUT = out_reg.cs_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence s_stretch_done;
      state_reg == ST_STRETCH && cnt_done && !sup_inv;
   endsequence
   sequence s_run_fresh;
      state_reg == ST_RUN && cnt_reg == 13'h0000 && long_reg && RESET_N_OUT;
   endsequence
   sequence s_timeout;
      state_reg == ST_RUN && cnt_done && !edge_seen && !WATCHDOG_STROBE_FLOAT_IN && !sup_inv;
   endsequence

   chk_reset_inverse: assert property (RESET_OUT == !RESET_N_OUT)
      else $error("high reset not inverse of low reset");
   chk_release_restart: assert property (s_stretch_done |=> s_run_fresh)
      else $error("release did not start long watchdog period");
   chk_timeout_pulse: assert property (s_timeout |=> !RESET_N_OUT && !WATCHDOG_EXPIRED_N_OUT
                                       && state_reg == ST_STRETCH)
      else $error("timeout did not drive reset and expired low");
   chk_supply_low_reset: assert property (sup_inv |=> !RESET_N_OUT && !SUPPLY_LOW_N_OUT
                                          && state_reg == ST_OFF)
      else $error("invalid supply did not hold reset");
   chk_low_flag_release: assert property (!sup_inv |=> SUPPLY_LOW_N_OUT)
      else $error("supply-low flag not released at once");
   chk_wdo_edge_clear: assert property (edge_seen |=> WATCHDOG_EXPIRED_N_OUT)
      else $error("expired flag not cleared by strobe edge");
   chk_float_hold: assert property (state_reg == ST_RUN && WATCHDOG_STROBE_FLOAT_IN && !sup_inv
                                    |=> cnt_reg == 13'h0000 && RESET_N_OUT)
      else $error("floating strobe did not disable watchdog");
   chk_edge_restart: assert property (state_reg == ST_RUN && edge_seen && !sup_inv
                                      |=> cnt_reg == 13'h0000 && !long_reg)
      else $error("strobe edge did not restart short period");
   chk_backup_levels: assert property (backup |=> ON_BATTERY_FLAG_OUT && !POWERFAIL_WARN_N_OUT
                                       && WATCHDOG_EXPIRED_N_OUT && RESET_OUT)
      else $error("back-up levels wrong");
   chk_cs_gate: assert property (sup_inv |=> CHIP_SELECT_N_OUT)
      else $error("chip-select not forced high");
   chk_cs_follow: assert property (!sup_inv |=> CHIP_SELECT_N_OUT == $past(CHIP_SELECT_N_IN))
      else $error("chip-select not copied");
endmodule : ssl_supervisor

// ---- ssl_pkg.sv ----
// Shared constants and carrier types for the supply supervisor logic
package ssl_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W = 13;
   localparam int RESET_MS = 200;
   localparam int WD_SHORT_MS = 100;
   localparam int WD_LONG_MS = 1600;
   localparam logic [CNT_W-1:0] INT_RESET_TICKS = CNT_W'(RESET_MS * 1000 / TICK_US);
   localparam logic [CNT_W-1:0] INT_SHORT_TICKS = CNT_W'(WD_SHORT_MS * 1000 / TICK_US);
   localparam logic [CNT_W-1:0] INT_LONG_TICKS = CNT_W'(WD_LONG_MS * 1000 / TICK_US);
   localparam logic [CNT_W-1:0] EXT_RESET_CLKS = 13'h0800;
   localparam logic [CNT_W-1:0] EXT_SHORT_CLKS = 13'h0400;
   localparam logic [CNT_W-1:0] EXT_LONG_CLKS = 13'h1000;
   // ----------------------------------------------------------------
   // Period kinds and states
   // ----------------------------------------------------------------
   localparam logic [1:0] KIND_RESET = 2'h0;
   localparam logic [1:0] KIND_SHORT = 2'h1;
   localparam logic [1:0] KIND_LONG = 2'h2;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_STRETCH = 2'b01,
      ST_RUN = 2'b10
   } ssl_state_t;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic below_batt;
      logic below_thr;
      logic pf_ok;
   } ssl_cmp_t;
   typedef struct packed {
      logic reset_n;
      logic reset;
      logic low_n;
      logic wdo_n;
      logic pfo_n;
      logic on_batt;
      logic cs_n;
   } ssl_out_t;
   localparam ssl_cmp_t CMP_RST = 3'h6;
   localparam ssl_out_t OUT_RST = 7'h29;
endpackage : ssl_pkg

// ---- ssl_sync.sv ----
// Two-stage synchroniser for comparator decisions
`timescale 1ns/1ps
module ssl_sync
   import ssl_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire ssl_cmp_t d_in,
   output ssl_cmp_t q_out
);
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   genvar i;
   // ----------------------------------------------------------------
   // One pair of flops per bit
   // ----------------------------------------------------------------
   generate
      for (i = 0; i < 3; i++) begin : g_bit
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               meta_reg[i] <= CMP_RST[i];
               sync_reg[i] <= CMP_RST[i];
            end else begin
               meta_reg[i] <= d_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign q_out = sync_reg;
endmodule : ssl_sync

// ---- ssl_cpu_model.sv ----
// Processor-side model: watchdog strobe and memory chip select
`timescale 1ns/1ps
module ssl_cpu_model
#(
   parameter int HALF = 200
)(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic toggle_in,
   input wire logic poke_in,
   input wire logic float_in,
   input wire logic cs_n_in,
   output logic strobe_out,
   output logic float_out,
   output logic cs_n_out
);
   // ----------------------------------------------------------------
   // Strobe generator
   // ----------------------------------------------------------------
   int cnt_reg;
   logic lvl_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= 0;
         lvl_reg <= 1'h0;
      end else begin
         cnt_reg <= (cnt_reg == HALF - 1) ? 0 : cnt_reg + 1;
         // Service faster than the short period
         if (poke_in || (toggle_in && cnt_reg == HALF - 1)) begin
            lvl_reg <= ~lvl_reg;
         end
      end
   end
   // Released line wanders every cycle, so a float must not count as edges
   assign strobe_out = float_in ? cnt_reg[0] : lvl_reg;
   assign float_out = float_in;
   assign cs_n_out = cs_n_in;
endmodule : ssl_cpu_model

// ---- ssl_supervisor_tb.sv ----
// Self-checking testbench for the supply supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ssl_supervisor_tb;
   import ssl_pkg::*;
   localparam int TC = 4;
   localparam int STR = int'(INT_RESET_TICKS) * TC;
   localparam int LNG = int'(INT_LONG_TICKS) * TC;
   localparam int SHT = int'(INT_SHORT_TICKS) * TC;
   // External ticks are pin rising edges, one every two cycles
   localparam int XSH = int'(EXT_SHORT_CLKS) * 2;
   localparam int XST = int'(EXT_RESET_CLKS) * 2;
   logic clk = 1'h0;
   logic rst = 1'h1, thr = 1'h1, batt = 1'h0, pf = 1'h1, tog = 1'h0, poke = 1'h0;
   logic flt = 1'h0, csq = 1'h1, sel = 1'h1, pin = 1'h0, pin_run = 1'h0;
   logic stb, sfl, csi, rn, r, lown, wdon, pfon, onb, csn;
   int n_mismatch = 0, compares = 0, cyc = 0;
   always #50 clk = ~clk;
   always @(posedge clk) pin <= pin_run ? ~pin : pin;
   ssl_cpu_model i_ssl_cpu_model (.clk_in(clk), .rst_in(rst), .toggle_in(tog),
      .poke_in(poke), .float_in(flt), .cs_n_in(csq), .strobe_out(stb),
      .float_out(sfl), .cs_n_out(csi));
   ssl_supervisor #(.TICK_CYCLES(TC)) i_ssl_supervisor (.REF_CLK_IN(clk), .RST_IN(rst),
      .SUPPLY_BELOW_THR_IN(thr), .SUPPLY_BELOW_BATT_IN(batt), .POWERFAIL_SENSE_IN(pf),
      .WATCHDOG_STROBE_IN(stb), .WATCHDOG_STROBE_FLOAT_IN(sfl), .CHIP_SELECT_N_IN(csi),
      .TIMEBASE_SELECT_IN(sel), .TIMEBASE_PIN_IN(pin), .RESET_N_OUT(rn), .RESET_OUT(r),
      .SUPPLY_LOW_N_OUT(lown), .WATCHDOG_EXPIRED_N_OUT(wdon), .POWERFAIL_WARN_N_OUT(pfon),
      .ON_BATTERY_FLAG_OUT(onb), .CHIP_SELECT_N_OUT(csn));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic close_out;
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic power_up;
      thr <= 1'h0;
      tick(6);
      @(negedge clk);
      `CHK(lown, 1'h1)
      `CHK(rn, 1'h0)
      tick(STR - 30);
      @(negedge clk);
      `CHK(r, 1'h1)
      tick(40);
      @(negedge clk);
      `CHK(rn, 1'h1)
      `CHK(r, 1'h0)
      tick(1);
   endtask : power_up
   task automatic cs_pf;
      csq <= 1'h0;
      pf <= 1'h0;
      tick(5);
      @(negedge clk);
      `CHK(csn, 1'h0)
      `CHK(pfon, 1'h0)
      tick(1);
      csq <= 1'h1;
      pf <= 1'h1;
      tick(5);
      @(negedge clk);
      `CHK(csn, 1'h1)
      `CHK(pfon, 1'h1)
   endtask : cs_pf
   task automatic wd_static;
      tick(LNG - 400);
      @(negedge clk);
      `CHK(wdon, 1'h1)
      tick(1);
      poke <= 1'h1;
      tick(1);
      poke <= 1'h0;
      tick(SHT - 40);
      @(negedge clk);
      `CHK(wdon, 1'h1)
      tick(80);
      @(negedge clk);
      `CHK(wdon, 1'h0)
      `CHK(rn, 1'h0)
      tick(STR - 80);
      @(negedge clk);
      `CHK(rn, 1'h0)
      tick(80);
      @(negedge clk);
      `CHK(rn, 1'h1)
      `CHK(wdon, 1'h0)
      tick(1);
      csq <= 1'h0;
      thr <= 1'h1;
      tick(6);
      @(negedge clk);
      `CHK(wdon, 1'h1)
      `CHK(lown, 1'h0)
      `CHK(rn, 1'h0)
      `CHK(csn, 1'h1)
      tick(SHT + 40);
      @(negedge clk);
      `CHK(rn, 1'h0)
      tick(1);
      thr <= 1'h0;
      tick(6);
      @(negedge clk);
      `CHK(lown, 1'h1)
      `CHK(rn, 1'h0)
      tick(STR + 40);
      @(negedge clk);
      `CHK(rn, 1'h1)
      `CHK(csn, 1'h0)
      tick(1);
   endtask : wd_static
   task automatic wd_serviced;
      tog <= 1'h1;
      tick(SHT * 5);
      @(negedge clk);
      `CHK(wdon, 1'h1)
      `CHK(rn, 1'h1)
      tick(1);
      tog <= 1'h0;
      flt <= 1'h1;
      tick(LNG + 400);
      @(negedge clk);
      `CHK(wdon, 1'h1)
      `CHK(rn, 1'h1)
      tick(1);
      flt <= 1'h0;
   endtask : wd_serviced
   task automatic ext_clock;
      sel <= 1'h0;
      pin_run <= 1'h1;
      tick(XSH - 40);
      @(negedge clk);
      `CHK(rn, 1'h1)
      tick(80);
      @(negedge clk);
      `CHK(rn, 1'h0)
      `CHK(wdon, 1'h0)
      tick(XST - 80);
      @(negedge clk);
      `CHK(rn, 1'h0)
      tick(80);
      @(negedge clk);
      `CHK(rn, 1'h1)
      tick(1);
      poke <= 1'h1;
      sel <= 1'h1;
      pin_run <= 1'h0;
      tick(1);
      poke <= 1'h0;
      tick(4);
      @(negedge clk);
      `CHK(wdon, 1'h1)
      tick(1);
   endtask : ext_clock
   task automatic backup;
      batt <= 1'h1;
      tog <= 1'h1;
      tick(6);
      @(negedge clk);
      for (int i = 0; i < 2; i++) begin
         `CHK({onb, pfon, rn, r, lown, wdon, csn}, 7'h4B)
         tick(SHT + 600);
         sel <= 1'h0;
         pin_run <= 1'h1;
         csq <= 1'h1;
         tick(2);
         csq <= 1'h0; // Held select must stay blocked
         tick(8);
         @(negedge clk);
      end
      `CHK(wdon, 1'h1)
      `CHK(rn, 1'h0)
   endtask : backup
   initial begin
      tick(19);
      @(negedge clk);
      `CHK({rn, r, onb, csn}, 4'h5)
      tick(1);
      rst <= 1'h0;
      tick(2);
      power_up();
      cs_pf();
      wd_static();
      wd_serviced();
      ext_clock();
      backup();
      close_out();
   end
endmodule : ssl_supervisor_tb
